// *** rtl/sss_top.sv ***
// Safety stop supervisor for one servo axis: delayed stop functions,
// active stop and its status bits, hard power cutoff.
// Assumes host signals share sys_clk; pin inputs are asynchronous.
// Notes on behaviour
// - Delayed base block: decelerate, then cut power.
// - Monitor expiry: safe state, power off, disabled for base block; position/speed monitors start otherwise.
// - Position monitor checks travel after deceleration.
// - Speed limit checks speed after deceleration.
// - Request back ON restores normal operation.
// - Request OFF starts active stop deceleration.
// - Torque modes: servo off immediately.
// - Base block: decelerate, then servo off.
// - Position monitor: decelerate, then hold servo locked.
// - Profile position: bits 8,15 set, 12 cleared.
// - Homing: bits 8, 13, 15 set.
// - Cyclic modes: bits 8,15 set, 12 cleared.
// - Interpolated: bits 8,15 set, 12 cleared.
// - Profile velocity/torque: only bits 8, 15.
// - Release needs inputs ON, hold time, command.
// - Homing, profile position: no command needed.
// - After hard cutoff, inputs ON restore operation.
// - No safety device: no current, base block shown.
// - Either cutoff input OFF removes power promptly.
`include "sss_params.svh"
module sss_top #(
    parameter int unsigned MS_CYC  = `SSS_MS_CYC,
    parameter int unsigned CUT_MAX = `SSS_CUT_MAX_CYC
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 safe_req_on,
    input  wire logic                 cutoff_request_ch1,
    input  wire logic                 cutoff_request_ch2,
    input  wire logic                 safety_dev_present,
    input  wire sss_pkg::sss_func_t   func_sel,
    input  wire sss_pkg::sss_mode_t   op_mode,
    input  wire logic [`SSS_CW_W-1:0] ctrl_word,
    input  wire logic                 param_set_sel,
    input  wire logic [`SSS_TW-1:0]   decel_rate_param_1,
    input  wire logic [`SSS_TW-1:0]   decel_rate_param_2,
    input  wire logic [`SSS_TW-1:0]   decel_monitor_time_1,
    input  wire logic [`SSS_TW-1:0]   decel_monitor_time_2,
    input  wire logic [`SSS_TW-1:0]   active_stop_hold_time,
    input  wire logic [`SSS_PW-1:0]   pos_travel,
    input  wire logic [`SSS_PW-1:0]   pos_limit,
    input  wire logic [`SSS_PW-1:0]   speed_abs,
    input  wire logic [`SSS_PW-1:0]   speed_limit,
    output logic                      motor_power_en,
    output logic                      servo_on,
    output logic                      decel_cmd,
    output logic [`SSS_TW-1:0]        decel_rate_ref,
    output sss_pkg::sss_status_t      status_bits
);
    sss_pkg::sss_top_t      r_reg;
    sss_pkg::sss_top_t      r_next;
    logic [`SSS_NPIN-1:0]   pins_s;
    logic                   req_on;
    logic                   cut_ok;
    logic                   tick;
    logic                   torque;
    logic                   cmd_ok;
    logic                   dm_start;
    logic                   dm_done;
    logic                   hd_start;
    logic                   hd_done;
    logic                   pos_bad;
    logic                   spd_bad;
    logic                   as_rel;

    sss_sync #(
        .WIDTH (`SSS_NPIN)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pin_in   ({safety_dev_present, cutoff_request_ch2,
                    cutoff_request_ch1, safe_req_on}),
        .pin_sync (pins_s)
    );

    sss_timer u_dm_tmr (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (dm_start),
        .tick    (tick),
        .load    (param_set_sel ? decel_monitor_time_2
                                : decel_monitor_time_1),
        .done    (dm_done)
    );

    sss_timer u_hd_tmr (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (hd_start),
        .tick    (tick),
        .load    (active_stop_hold_time),
        .done    (hd_done)
    );

    assign req_on  = pins_s[`SSS_PIN_REQ];
    // Power is allowed only with both cutoff channels ON and a device
    // or bypass jumper fitted.
    assign cut_ok  = pins_s[`SSS_PIN_CH1] && pins_s[`SSS_PIN_CH2]
                     && pins_s[`SSS_PIN_DEV];
    assign tick    = (r_reg.div == `SSS_DIV_W'(MS_CYC - 1));
    assign torque  = (op_mode == sss_pkg::SSS_M_PT)
                     || (op_mode == sss_pkg::SSS_M_CST);
    assign pos_bad = (pos_travel > pos_limit);
    assign spd_bad = (speed_abs > speed_limit);
    // Not while decelerating: the hold done flag may be from a past stop.
    assign as_rel  = r_reg.as_act && req_on && hd_done && cmd_ok
                     && r_reg.st != sss_pkg::SSS_ST_DECEL;

    // Controller command that the current mode needs for release.
    always_comb begin
        case (op_mode)
            sss_pkg::SSS_M_IP:
                cmd_ok = ctrl_word[`SSS_CW_HALT]
                         || !ctrl_word[`SSS_CW_INTP];
            sss_pkg::SSS_M_CSP, sss_pkg::SSS_M_CSV, sss_pkg::SSS_M_PV:
                cmd_ok = ctrl_word[`SSS_CW_HALT];
            sss_pkg::SSS_M_PT, sss_pkg::SSS_M_CST:
                cmd_ok = ctrl_word[`SSS_CW_SW_ON]
                         && ctrl_word[`SSS_CW_EN_VOLT];
            default:
                cmd_ok = 1'b1;
        endcase
    end

    always_comb begin
        r_next   = r_reg;
        dm_start = 1'b0;
        hd_start = 1'b0;
        r_next.div = tick ? '0 : r_reg.div + 1'b1;
        case (r_reg.st)
            sss_pkg::SSS_ST_RUN: begin
                if (!req_on && func_sel != sss_pkg::SSS_F_NONE) begin
                    if (func_sel != sss_pkg::SSS_F_DSL) begin
                        r_next.as_act = 1'b1;
                    end
                    if (torque && func_sel != sss_pkg::SSS_F_DSL) begin
                        r_next.st = sss_pkg::SSS_ST_BB;
                    end else begin
                        r_next.st = sss_pkg::SSS_ST_DECEL;
                        dm_start  = 1'b1;
                    end
                end
            end
            sss_pkg::SSS_ST_DECEL: begin
                if (req_on && !r_reg.as_act) begin
                    r_next.st = sss_pkg::SSS_ST_RUN;
                end else if (dm_done) begin
                    if (func_sel == sss_pkg::SSS_F_DBB) begin
                        r_next.st = sss_pkg::SSS_ST_BB;
                    end else begin
                        r_next.st = sss_pkg::SSS_ST_MON;
                    end
                end
            end
            sss_pkg::SSS_ST_MON: begin
                if ((func_sel == sss_pkg::SSS_F_DPM && pos_bad)
                    || (func_sel == sss_pkg::SSS_F_DSL && spd_bad)) begin
                    r_next.st = sss_pkg::SSS_ST_BB;
                end else if (req_on && !r_reg.as_act) begin
                    r_next.st = sss_pkg::SSS_ST_RUN;
                end
            end
            default: begin
                if (req_on && cut_ok && !r_reg.as_act) begin
                    r_next.st = sss_pkg::SSS_ST_RUN;
                end
            end
        endcase
        // The stop ends only when all conditions hold, and the state leaves
        // on that edge so bits 8 and 15 drop together; a limit trip wins.
        if (as_rel) begin
            r_next.as_act = 1'b0;
            if (r_reg.st == sss_pkg::SSS_ST_BB
                || r_next.st != sss_pkg::SSS_ST_BB) begin
                r_next.st = sss_pkg::SSS_ST_RUN;
            end
        end
        if (!cut_ok) begin
            r_next.st = sss_pkg::SSS_ST_BB;
        end
        // The hold time runs from when the stop leaves deceleration, or from its start when a torque mode skips it.
        hd_start = r_next.as_act && r_next.st != sss_pkg::SSS_ST_DECEL
                   && (r_reg.st == sss_pkg::SSS_ST_DECEL || !r_reg.as_act);
        r_next.pwr = cut_ok && r_next.st != sss_pkg::SSS_ST_BB;
        r_next.srv = r_next.pwr;
        r_next.dec = r_next.st == sss_pkg::SSS_ST_DECEL;
        r_next.rate = param_set_sel ? decel_rate_param_2
                                    : decel_rate_param_1;
        r_next.sw.sod = r_next.st == sss_pkg::SSS_ST_BB;
        r_next.sw.b8  = r_next.as_act;
        r_next.sw.b15 = r_next.as_act
                        || r_next.st != sss_pkg::SSS_ST_RUN;
        r_next.sw.b12_clr = r_next.as_act
                            && (op_mode == sss_pkg::SSS_M_PP
                                || op_mode == sss_pkg::SSS_M_IP
                                || op_mode == sss_pkg::SSS_M_CSP
                                || op_mode == sss_pkg::SSS_M_CSV
                                || op_mode == sss_pkg::SSS_M_CST);
        r_next.sw.b13_set = r_next.as_act
                            && op_mode == sss_pkg::SSS_M_HM;
    end

    // Reset lands in base block with power off until inputs are seen.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg      <= '0;
            r_reg.st   <= sss_pkg::SSS_ST_BB;
            r_reg.rate <= `SSS_RATE_RST;
            r_reg.sw   <= `SSS_SW_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign motor_power_en = r_reg.pwr;
    assign servo_on       = r_reg.srv;
    assign decel_cmd      = r_reg.dec;
    assign decel_rate_ref = r_reg.rate;
    assign status_bits    = r_reg.sw;

    // Cycles for which power has stayed on with cutoff requested.
    logic [31:0] cut_cnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cut_cnt <= '0;
        end else if (!cut_ok && motor_power_en) begin
            cut_cnt <= cut_cnt + 1'b1;
        end else begin
            cut_cnt <= '0;
        end
    end

    AST_CUT_BOUND: assert property (
        @(posedge sys_clk) disable iff (!rst_n) cut_cnt < CUT_MAX)
        else $error("Power stayed on past the cutoff limit.");

    AST_CUT_POWER: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !cut_ok |=> !motor_power_en && !servo_on)
        else $error("Cutoff input OFF did not remove power.");

    AST_NO_DEVICE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !pins_s[`SSS_PIN_DEV] [*2] |-> status_bits.sod && !motor_power_en)
        else $error("Missing safety device did not block power.");

    AST_DBB_EXPIRE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r_reg.st == sss_pkg::SSS_ST_DECEL && dm_done && cut_ok
        && func_sel == sss_pkg::SSS_F_DBB && !(req_on && !r_reg.as_act)
        |=> !motor_power_en && status_bits.sod)
        else $error("Monitor expiry did not enter base block.");

    AST_DECEL_START: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r_reg.st == sss_pkg::SSS_ST_RUN && !req_on && !torque && cut_ok
        && func_sel == sss_pkg::SSS_F_DBB
        |=> decel_cmd && servo_on && status_bits.b8)
        else $error("Request OFF did not start deceleration.");

    AST_TORQUE_OFF: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r_reg.st == sss_pkg::SSS_ST_RUN && !req_on && torque
        && func_sel != sss_pkg::SSS_F_NONE
        && func_sel != sss_pkg::SSS_F_DSL |=> !servo_on ##1 !servo_on)
        else $error("Torque mode did not turn the servo off.");

    AST_DPM_LOCK: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r_reg.st == sss_pkg::SSS_ST_DECEL && dm_done && cut_ok
        && r_reg.as_act && func_sel == sss_pkg::SSS_F_DPM
        |=> servo_on && !decel_cmd)
        else $error("Position monitor did not hold the servo.");

    AST_MON_TRIP: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r_reg.st == sss_pkg::SSS_ST_MON
        && ((func_sel == sss_pkg::SSS_F_DPM && pos_bad)
            || (func_sel == sss_pkg::SSS_F_DSL && spd_bad))
        |=> !motor_power_en)
        else $error("Limit violation did not cut power.");

    AST_RELEASE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        status_bits.b8 && !(req_on && hd_done && cmd_ok
                            && r_reg.st != sss_pkg::SSS_ST_DECEL)
        |=> status_bits.b8)
        else $error("Active stop cleared too early.");

    AST_CLEAR_BITS: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r_reg.as_act && req_on && hd_done && cmd_ok && cut_ok
        && r_reg.st != sss_pkg::SSS_ST_DECEL
        && !(r_reg.st == sss_pkg::SSS_ST_MON && (pos_bad || spd_bad))
        |=> !status_bits.b8 && !status_bits.b15)
        else $error("Bits 8 and 15 did not clear together.");

    AST_HOMING_BITS: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        status_bits.b8 && $past(op_mode) == sss_pkg::SSS_M_HM
        |-> status_bits.b13_set && status_bits.b15 && !status_bits.b12_clr)
        else $error("Homing active stop bits wrong.");

    AST_PP_BITS: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        status_bits.b8 && $past(op_mode) != sss_pkg::SSS_M_HM
        |-> status_bits.b15 && !status_bits.b13_set
            && (status_bits.b12_clr == ($past(op_mode) != sss_pkg::SSS_M_PV
                && $past(op_mode) != sss_pkg::SSS_M_PT
                && $past(op_mode) != sss_pkg::SSS_M_NONE)))
        else $error("Active stop status bits wrong for mode.");

    AST_RESUME: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r_reg.st != sss_pkg::SSS_ST_RUN && req_on && cut_ok
        && !r_reg.as_act && !(r_reg.st == sss_pkg::SSS_ST_MON
                              && (pos_bad || spd_bad))
        |=> motor_power_en && !status_bits.b15)
        else $error("Inputs ON did not restore operation.");
endmodule

// *** rtl/sss_params.svh ***
// Constants of the safety stop supervisor: timing, bit positions, codes.
// Assumes every file that uses these names includes it itself.
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH
`define SSS_CLK_MHZ     250
`define SSS_MS_CYC      (1000 * `SSS_CLK_MHZ)
`define SSS_CUT_MAX_MS  8
`define SSS_CUT_MAX_CYC (`SSS_CUT_MAX_MS * `SSS_MS_CYC)
`define SSS_DIV_W       18
`define SSS_TW          16
`define SSS_PW          32
`define SSS_CW_W        16
`define SSS_NPIN        4
`define SSS_PIN_REQ     0
`define SSS_PIN_CH1     1
`define SSS_PIN_CH2     2
`define SSS_PIN_DEV     3
`define SSS_CW_SW_ON    1
`define SSS_CW_EN_VOLT  2
`define SSS_CW_INTP     4
`define SSS_CW_HALT     8
`define SSS_SYNC_RST    4'h0
`define SSS_TMR_RST     16'h0000
`define SSS_RATE_RST    16'h0000
`define SSS_SW_RST      5'h10
`endif

// *** rtl/sss_pkg.sv ***
// Types of the safety stop supervisor.
// Assumes sss_params.svh is on the include path.
`include "sss_params.svh"
package sss_pkg;
    typedef enum logic [1:0] {
        SSS_ST_RUN   = 2'h0,
        SSS_ST_DECEL = 2'h1,
        SSS_ST_MON   = 2'h2,
        SSS_ST_BB    = 2'h3
    } sss_state_t;

    typedef enum logic [1:0] {
        SSS_F_NONE = 2'h0,
        SSS_F_DBB  = 2'h1,
        SSS_F_DPM  = 2'h2,
        SSS_F_DSL  = 2'h3
    } sss_func_t;

    typedef enum logic [3:0] {
        SSS_M_NONE = 4'h0,
        SSS_M_PP   = 4'h1,
        SSS_M_PV   = 4'h3,
        SSS_M_PT   = 4'h4,
        SSS_M_HM   = 4'h6,
        SSS_M_IP   = 4'h7,
        SSS_M_CSP  = 4'h8,
        SSS_M_CSV  = 4'h9,
        SSS_M_CST  = 4'hA
    } sss_mode_t;

    typedef struct packed {
        logic sod;
        logic b8;
        logic b12_clr;
        logic b13_set;
        logic b15;
    } sss_status_t;

    typedef struct packed {
        logic [`SSS_TW-1:0] cnt;
        logic               run;
        logic               done;
    } sss_tmr_t;

    typedef struct packed {
        sss_state_t            st;
        logic                  as_act;
        logic [`SSS_DIV_W-1:0] div;
        logic                  pwr;
        logic                  srv;
        logic                  dec;
        logic [`SSS_TW-1:0]    rate;
        sss_status_t           sw;
    } sss_top_t;
endpackage

// *** rtl/sss_sync.sv ***
// Two flip-flop synchroniser for the asynchronous safety pins.
// Assumes pins settle to OFF (low) as the safe reading at reset.
`include "sss_params.svh"
module sss_sync #(
    parameter int WIDTH = `SSS_NPIN
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= WIDTH'(`SSS_SYNC_RST);
            pin_sync <= WIDTH'(`SSS_SYNC_RST);
        end else begin
            meta_reg <= pin_in;
            pin_sync <= meta_reg;
        end
    end
endmodule

// *** rtl/sss_timer.sv ***
// Millisecond down timer: loaded by start, counts on tick, flags done.
// Assumes tick is a one-cycle enable pulse from the top's divider.
`include "sss_params.svh"
module sss_timer (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               start,
    input  wire logic               tick,
    input  wire logic [`SSS_TW-1:0] load,
    output logic                    done
);
    sss_pkg::sss_tmr_t r_reg;
    sss_pkg::sss_tmr_t r_next;

    // Done stays high until the next start.
    always_comb begin
        r_next = r_reg;
        if (start) begin
            r_next.cnt  = load;
            r_next.run  = 1'b1;
            r_next.done = 1'b0;
        end else if (tick && r_reg.run) begin
            if (r_reg.cnt == `SSS_TMR_RST) begin
                r_next.run  = 1'b0;
                r_next.done = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign done = r_reg.done;
endmodule

// *** tb/sss_host_model.sv ***
// Host motion controller model that drives the control word of the block.
// Assumes status_bits and op_mode share sys_clk; cmd_en low withholds the
// stop reply, so the bench can show that a release waits for it.
`include "sss_params.svh"
module sss_host_model (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire sss_pkg::sss_status_t status_bits,
    input  wire sss_pkg::sss_mode_t   op_mode,
    input  wire logic                 cmd_en,
    output logic [`SSS_CW_W-1:0]      ctrl_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic torque;
    assign torque = (op_mode == sss_pkg::SSS_M_PT)
                 || (op_mode == sss_pkg::SSS_M_CST);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_word <= 16'h0011;
        end else if (!cmd_en) begin
            // Interpolation enabled, no halt, switch-on and enable-voltage bits off.
            ctrl_word <= 16'h0011;
        end else if (status_bits.b8 || status_bits.b15) begin
            if (torque) begin
                ctrl_word <= 16'h0006;
            end else begin
                ctrl_word <= 16'h0110;
            end
        end else begin
            ctrl_word <= 16'h001F;
        end
    end
endmodule

// *** tb/sss_tb.sv ***
// Self-checking bench of the safety stop supervisor with a host model.
// Assumes the design files and sss_host_model are compiled before it.
`include "sss_params.svh"
`define SSS_CHECK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("wrong value at %0t: got %h expected %h", \
                     $time, got, exp); \
        end \
    end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [23:0] exp;
        logic [23:0] mask;
    } sss_note_t;
    localparam int unsigned MS = 4;
    logic                     sys_clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     safe_req_on = 1'b1;
    logic                     cutoff_request_ch1 = 1'b1;
    logic                     cutoff_request_ch2 = 1'b1;
    logic                     safety_dev_present = 1'b1;
    sss_pkg::sss_func_t       func_sel = sss_pkg::SSS_F_NONE;
    sss_pkg::sss_mode_t       op_mode = sss_pkg::SSS_M_PP;
    logic                     param_set_sel = 1'b0;
    logic                     cmd_en = 1'b1;
    logic                     sel;
    logic [`SSS_TW-1:0]       decel_rate_param_1 = 16'h0000;
    logic [`SSS_TW-1:0]       decel_rate_param_2 = 16'h0000;
    logic [`SSS_TW-1:0]       decel_monitor_time_1 = 16'h0003;
    logic [`SSS_TW-1:0]       decel_monitor_time_2 = 16'h0004;
    logic [`SSS_TW-1:0]       active_stop_hold_time = 16'h0002;
    logic [`SSS_PW-1:0]       pos_travel = 32'h0000_1000;
    logic [`SSS_PW-1:0]       pos_limit = 32'h0000_1000;
    logic [`SSS_PW-1:0]       speed_abs = 32'h0000_0800;
    logic [`SSS_PW-1:0]       speed_limit = 32'h0000_0800;
    logic [`SSS_CW_W-1:0]     ctrl_word;
    logic                     motor_power_en;
    logic                     servo_on;
    logic                     decel_cmd;
    logic [`SSS_TW-1:0]       decel_rate_ref;
    sss_pkg::sss_status_t     status_bits;
    logic [23:0]              obs;
    sss_note_t                notes[$];
    event                     got_ev;
    int                       num_errors = 0;
    int                       num_checks = 0;
    logic [3:0]  md [8] = '{4'h1, 4'h6, 4'h7, 4'h8, 4'h9, 4'h3, 4'h4, 4'hA};
    logic [23:0] ee [8] = '{24'hED, 24'hEB, 24'hED, 24'hED, 24'hED, 24'hE9,
                            24'h09, 24'h0D};
    logic [23:0] em [8] = '{24'hFF, 24'hFF, 24'hFF, 24'hFF, 24'hFF, 24'hFF,
                            24'hCF, 24'hCF};

    assign obs = {decel_rate_ref, motor_power_en, servo_on, decel_cmd,
                  status_bits};

    sss_top #(.MS_CYC(MS), .CUT_MAX(8 * MS)) u_sss_top (
        .sys_clk, .rst_n, .safe_req_on, .cutoff_request_ch1,
        .cutoff_request_ch2, .safety_dev_present, .func_sel, .op_mode,
        .ctrl_word, .param_set_sel, .decel_rate_param_1, .decel_rate_param_2,
        .decel_monitor_time_1, .decel_monitor_time_2, .active_stop_hold_time,
        .pos_travel, .pos_limit, .speed_abs, .speed_limit, .motor_power_en,
        .servo_on, .decel_cmd, .decel_rate_ref, .status_bits
    );
    sss_host_model u_sss_host_model (
        .sys_clk, .rst_n, .status_bits, .op_mode, .cmd_en, .ctrl_word
    );

    always #2 sys_clk = ~sys_clk;

    // Waits up to n cycles for the masked pattern, then notes the expectation.
    task automatic see(input logic [23:0] e, input logic [23:0] m,
                       input int n);
        sss_note_t note;
        note.exp = e & m;
        note.mask = m;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            #1;
            if ((obs & m) === note.exp) break;
        end
        notes.push_back(note);
        -> got_ev;
    endtask

    always @(got_ev) begin
        sss_note_t note;
        note = notes.pop_front();
        `SSS_CHECK(obs & note.mask, note.exp)
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic violate(input logic spd);
        @(posedge sys_clk);
        func_sel <= spd ? sss_pkg::SSS_F_DSL : sss_pkg::SSS_F_DPM;
        @(posedge sys_clk);
        safe_req_on <= 1'b0;
        see(24'hC1, 24'hE1, 45);
        @(posedge sys_clk);
        if (spd) speed_abs <= speed_limit + 32'h1;
        else pos_travel <= pos_limit + 32'h1;
        see(24'h01, 24'hC1, 5);
        @(posedge sys_clk);
        speed_abs <= speed_limit;
        pos_travel <= pos_limit;
        safe_req_on <= 1'b1;
        see(24'hC0, 24'hE9, 40);
        $display("monitor test %0d done", spd);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h51e9b664));
        decel_rate_param_1 = 16'($urandom);
        decel_rate_param_2 = 16'($urandom);
        pos_limit = $urandom_range(1000, 100000);
        speed_limit = $urandom_range(1000, 100000);
        pos_travel = pos_limit;
        speed_abs = speed_limit;
        sel = 1'($urandom);
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        param_set_sel <= sel;
        see(24'hC0, 24'hFF, 15);
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            {safety_dev_present, cutoff_request_ch2, cutoff_request_ch1}
                <= ~(3'b001 << k);
            see(24'h10, 24'hD0, 5);
            @(posedge sys_clk);
            {safety_dev_present, cutoff_request_ch2, cutoff_request_ch1}
                <= 3'b111;
            see(24'hC0, 24'hD0, 10);
        end
        $display("cutoff test done");
        @(posedge sys_clk);
        func_sel <= sss_pkg::SSS_F_DBB;
        @(posedge sys_clk);
        safe_req_on <= 1'b0;
        see({sel ? decel_rate_param_2 : decel_rate_param_1, 8'hED},
            24'hFFFFFF, 5);
        repeat (8) @(posedge sys_clk);
        see(24'hE0, 24'hE0, 1);
        see(24'h19, 24'hF9, 40);
        @(posedge sys_clk);
        safe_req_on <= 1'b1;
        see(24'hC0, 24'hE9, 40);
        $display("delayed stop test done");
        violate(1'b0);
        violate(1'b1);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            op_mode <= sss_pkg::sss_mode_t'(md[i]);
            func_sel <= (i >= 6) ? sss_pkg::SSS_F_DBB : sss_pkg::SSS_F_DPM;
            cmd_en <= 1'b0;
            repeat (4) @(posedge sys_clk);
            safe_req_on <= 1'b0;
            see(ee[i], em[i], 5);
            see(ee[i], em[i], 1);
            if (i < 6) see(24'hC9, 24'hE9, 40);
            @(posedge sys_clk);
            safe_req_on <= 1'b1;
            if (i >= 2) begin
                repeat (30) @(posedge sys_clk);
                see(24'h09, 24'h09, 1);
                @(posedge sys_clk);
                cmd_en <= 1'b1;
            end
            see(24'hC0, 24'hE9, 40);
            $display("active stop test %0d done", i);
        end
        @(posedge sys_clk);
        stop_test();
    end
endmodule
